// file: hw/flash_defines.svh
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH

// Recognised read opcodes.
`define OP_LEGACY     8'hE8
`define OP_FAST       8'h1B

// Bit counts since select, counted on rising serial clock edges.
`define OP_BITS       7'h08
`define HDR_BITS      7'h20
`define LEGACY_END    7'h40
`define FAST_END      7'h30

// Last byte offset of a page in each page-size mode, and the last page.
`define LAST_OFF_528  10'h20F
`define LAST_OFF_512  10'h1FF
`define LAST_PAGE     13'h1FFF

// Serial byte shifting.
`define BYTE_LAST     3'h7
`define UNDERRUN_BYTE 8'hFF

// Read-ahead buffer shape and the number of synchronised pins.
`define FIFO_DEPTH    8
`define FIFO_WIDTH    8
`define INFL_MAX      4'h8
`define SYNC_W        4
`define SYNC_RST      4'h9

`endif

// file: hw/flash_pkg.sv
package flash_pkg;

	// Command phases of the serial front end.
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} phase_t;

	// Complete state of the front end.
	typedef struct packed
	{
		phase_t      phase;
		logic        sck_d;
		logic [6:0]  bits;
		logic [7:0]  op;
		logic [23:0] addr;
		logic        pg512;
		logic [12:0] page;
		logic [9:0]  off;
		logic [9:0]  buf_off;
		logic [3:0]  infl;
		logic        pf_on;
		logic [7:0]  sh;
		logic [2:0]  bcnt;
		logic        so;
		logic        so_oe;
	} main_state_t;

endpackage

// file: hw/bit_sync.sv
module bit_sync
	import flash_pkg::*;
#(
	parameter int                WIDTH   = 1,
	parameter logic [WIDTH-1:0]  RST_VAL = '0
)
(
	input  wire logic             mclk,   // System clock.
	input  wire logic             reset,  // Synchronous reset, active high.
	input  wire logic [WIDTH-1:0] d,      // Asynchronous inputs.
	output logic      [WIDTH-1:0] q       // Synchronised outputs.
);

	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_t;

	sync_state_t st_ff;
	sync_state_t nxt_st;

	// The first stage feeds only the second stage, never any logic.
	always_comb
	begin
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			st_ff <= {RST_VAL, RST_VAL};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;

endmodule

// file: hw/stream_fifo.sv
module stream_fifo
	import flash_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic             mclk,       // System clock.
	input  wire logic             reset,      // Synchronous reset, active high.
	input  wire logic             in_valid,   // Write data offered.
	output logic                  in_ready,   // Space available.
	input  wire logic [WIDTH-1:0] in_data,    // Write data.
	output logic                  out_valid,  // Read data available.
	input  wire logic             out_ready,  // Reader takes the head word.
	output logic      [WIDTH-1:0] out_data    // Head word.
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fifo_state_t;

	fifo_state_t st_ff;
	fifo_state_t nxt_st;
	logic        push;
	logic        pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_ff.cnt != '0);
	assign out_data  = st_ff.mem[st_ff.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers wrap explicitly so a depth that is not a power of two also works.
	always_comb
	begin
		nxt_st = st_ff;
		if (push)
		begin
			nxt_st.mem[st_ff.wp] = in_data;
			nxt_st.wp = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : AW'(st_ff.wp + 1'b1);
		end
		if (pop)
		begin
			nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : AW'(st_ff.rp + 1'b1);
		end
		nxt_st.cnt = (AW+1)'(st_ff.cnt + push - pop);
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

endmodule

// file: hw/serial_flash_continuous_read.sv
`include "flash_defines.svh"
// Summary of operation
// - Select falling starts a command: 8-bit opcode, then address.
// - With select low each rising serial clock edge loads one SI bit.
// - All opcode, address and data bytes travel most significant bit first.
// - Always three address bytes; don't-care bits depend on operation and page size.
// - 528-byte pages: 13-bit page number, then 10-bit byte offset.
// - 528-byte pages: buffer byte address is 10 bits wide.
// - 512-byte pages: 9-bit buffer offset; 22-bit address, 13 page, 9 byte.
// - Opcode E8h: address, four dummy bytes, then data on SO.
// - Dummy bytes are read setup; no array data before they end.
// - Opcode 1Bh: address, two dummy bytes, then data on SO.
// - Internal address counter advances as data streams out.
// - End of page continues at next page without pause.
// - End of array wraps to first page without pause.
// - Select rising ends the read at once and floats SO.
// - Continuous reads come straight from the array, buffers untouched.
// - Works in serial clock modes 0 and 3.
// - SI sampled on rising edges, ignored while deselected.
// - SO changes on falling edges, floats while deselected.
// - Reset pin low aborts and holds idle until it rises.
module serial_flash_continuous_read
	import flash_pkg::*;
(
	input  wire logic        mclk,          // System clock, 10 MHz.
	input  wire logic        reset,         // Synchronous reset, active high.
	input  wire logic        rst_pin_n,     // Hardware reset pin, active low.
	input  wire logic        cs_n,          // Chip select pin, active low.
	input  wire logic        sck,           // Serial clock pin.
	input  wire logic        si,            // Serial data in pin.
	output logic             so,            // Serial data out.
	output logic             so_oe,         // Drive enable for serial data out.
	input  wire logic        page_size_512, // Page-size state, 1 selects 512.
	output logic             arr_req,       // Array byte read request.
	input  wire logic        arr_gnt,       // Array accepts the request.
	output logic      [12:0] arr_page,      // Requested page number.
	output logic      [9:0]  arr_off,       // Requested byte offset.
	input  wire logic        arr_rvalid,    // Array returns a byte.
	output logic             arr_rready,    // Read-ahead buffer has room.
	input  wire logic [7:0]  arr_rdata,     // Returned byte.
	output logic      [9:0]  cmd_buf_off    // Buffer byte offset of last address.
);

	main_state_t st_ff;
	main_state_t nxt_st;

	logic [`SYNC_W-1:0] sync_q;
	logic               cs_n_s;
	logic               sck_s;
	logic               si_s;
	logic               rstn_s;
	logic               sck_rise;
	logic               sck_fall;
	logic               fire;
	logic               pop;
	logic               load;
	logic               fifo_ovalid;
	logic [7:0]         fifo_odata;
	logic [9:0]         last_off;
	logic [6:0]         hdr_end;
	logic [6:0]         nbits;
	logic [7:0]         nop;
	logic [23:0]        naddr;
	logic [7:0]         byte_in;

	// Every pin crosses two flip-flops before any logic looks at it.
	bit_sync #(
		.WIDTH   (`SYNC_W),
		.RST_VAL (`SYNC_RST)
	) u_sync (
		.mclk  (mclk),
		.reset (reset),
		.d     ({rst_pin_n, si, sck, cs_n}),
		.q     (sync_q)
	);

	assign cs_n_s = sync_q[0];
	assign sck_s  = sync_q[1];
	assign si_s   = sync_q[2];
	assign rstn_s = sync_q[3];

	// edge based timing
	// Edges rather than levels make the idle clock level irrelevant.
	assign sck_rise = sck_s && !st_ff.sck_d;
	assign sck_fall = !sck_s && st_ff.sck_d;

	assign last_off = st_ff.pg512 ? `LAST_OFF_512 : `LAST_OFF_528;
	assign hdr_end  = (st_ff.op == `OP_LEGACY) ? `LEGACY_END : `FAST_END;

	// read only path
	// The array port only reads, and no buffer is touched on this path.
	assign arr_req  = st_ff.pf_on && (st_ff.infl < `INFL_MAX);
	assign fire     = arr_req && arr_gnt;
	assign arr_page = st_ff.page;
	assign arr_off  = st_ff.off;

	// Read-ahead buffer; requests are limited so it can never overflow.
	stream_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.in_valid  (arr_rvalid),
		.in_ready  (arr_rready),
		.in_data   (arr_rdata),
		.out_valid (fifo_ovalid),
		.out_ready (pop),
		.out_data  (fifo_odata)
	);

	// Stale bytes from an aborted read are discarded while prefetch is off.
	assign pop = fifo_ovalid && (load || !st_ff.pf_on);

	// Byte to shift next; an empty buffer means the host outran the array.
	assign byte_in = fifo_ovalid ? fifo_odata : `UNDERRUN_BYTE;

	// Next state of the command front end.
	always_comb
	begin
		nxt_st = st_ff;
		nbits = 7'(st_ff.bits + 7'h01);
		nop = {st_ff.op[6:0], si_s};
		naddr = {st_ff.addr[22:0], si_s};
		load = 1'b0;
		nxt_st.sck_d = sck_s;

		if (fire)
		begin
			if (st_ff.off >= last_off)
			begin
				nxt_st.off = '0;
				nxt_st.page = 13'(st_ff.page + 13'h0001);
			end
			else
			begin
				nxt_st.off = 10'(st_ff.off + 10'h001);
			end
		end
		// Prefetch starts only once earlier requests have all come home.
		nxt_st.pf_on = ((st_ff.phase == ST_DUMMY) || (st_ff.phase == ST_DATA))
			&& (st_ff.pf_on || (st_ff.infl == 4'h0));

		if (cs_n_s || !rstn_s)
		begin
			nxt_st.phase = ST_IDLE;
			nxt_st.bits = '0;
			nxt_st.so_oe = 1'b0;
			nxt_st.pf_on = 1'b0;
		end
		else
		begin
			case (st_ff.phase)
				ST_IDLE:
				begin
					nxt_st.phase = ST_OPCODE;
					nxt_st.pg512 = page_size_512;
					nxt_st.bits = '0;
				end
				ST_OPCODE:
				begin
					if (sck_rise)
					begin
						nxt_st.bits = nbits;
						nxt_st.op = nop;
						if (nbits == `OP_BITS)
						begin
							if ((nop == `OP_LEGACY) || (nop == `OP_FAST))
							begin
								nxt_st.phase = ST_ADDR;
							end
							else
							begin
								nxt_st.phase = ST_IGNORE;
							end
						end
					end
				end
				ST_ADDR:
				begin
					if (sck_rise)
					begin
						nxt_st.bits = nbits;
						nxt_st.addr = naddr;
						if (nbits == `HDR_BITS)
						begin
							nxt_st.phase = ST_DUMMY;
							if (st_ff.pg512)
							begin
								nxt_st.page = naddr[21:9];
								nxt_st.off = {1'b0, naddr[8:0]};
								nxt_st.buf_off = {1'b0, naddr[8:0]};
							end
							else
							begin
								nxt_st.page = naddr[22:10];
								nxt_st.off = naddr[9:0];
								nxt_st.buf_off = naddr[9:0];
							end
						end
					end
				end
				ST_DUMMY:
				begin
					if (sck_rise)
					begin
						nxt_st.bits = nbits;
						if (nbits == hdr_end)
						begin
							nxt_st.phase = ST_DATA;
							nxt_st.bcnt = '0;
						end
					end
				end
				ST_DATA:
				begin
					if (sck_fall)
					begin
						if (st_ff.bcnt == '0)
						begin
							load = 1'b1;
							nxt_st.so = byte_in[7];
							nxt_st.sh = {byte_in[6:0], 1'b0};
							nxt_st.bcnt = `BYTE_LAST;
							nxt_st.so_oe = 1'b1;
						end
						else
						begin
							nxt_st.so = st_ff.sh[7];
							nxt_st.sh = {st_ff.sh[6:0], 1'b0};
							nxt_st.bcnt = 3'(st_ff.bcnt - 3'h1);
						end
					end
				end
				ST_IGNORE:
				begin
					nxt_st.so_oe = 1'b0;
				end
				default:
				begin
					nxt_st.phase = ST_IDLE;
				end
			endcase
		end
		// Pop is rebuilt here from load, so this process never reads its own result.
		nxt_st.infl = 4'(st_ff.infl + {3'h0, fire} - {3'h0, fifo_ovalid && (load || !st_ff.pf_on)});
	end

	// Single register for the whole front end.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign so          = st_ff.so;
	assign so_oe       = st_ff.so_oe;
	assign cmd_buf_off = st_ff.buf_off;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	property p_oe_off_on_deselect;
		$rose(cs_n_s) |=> !so_oe;
	endproperty
	a_oe_off_on_deselect: assert property (p_oe_off_on_deselect)
		else $error("SO still driven after select rose");

	property p_drive_only_in_data;
		so_oe |-> (st_ff.phase == ST_DATA);
	endproperty
	a_drive_only_in_data: assert property (p_drive_only_in_data)
		else $error("SO driven outside the data phase");

	property p_legacy_len;
		(st_ff.phase == ST_DATA && st_ff.op == `OP_LEGACY) |-> (st_ff.bits == `LEGACY_END);
	endproperty
	a_legacy_len: assert property (p_legacy_len)
		else $error("Legacy read entered data with wrong bit count");

	property p_fast_len;
		(st_ff.phase == ST_DATA && st_ff.op == `OP_FAST) |-> (st_ff.bits == `FAST_END);
	endproperty
	a_fast_len: assert property (p_fast_len)
		else $error("Fast read entered data with wrong bit count");

	property p_ignore_quiet;
		(st_ff.phase == ST_IGNORE) |-> (!so_oe && !arr_req);
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet)
		else $error("Unknown opcode produced activity");

	property p_pin_reset;
		!rstn_s |=> (st_ff.phase == ST_IDLE) && !so_oe;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("Reset pin did not force idle");

	property p_so_falling_only;
		(so_oe && !sck_fall) |=> $stable(so);
	endproperty
	a_so_falling_only: assert property (p_so_falling_only)
		else $error("SO changed without a falling clock edge");

	property p_page_cross;
		(fire && st_ff.off >= last_off && st_ff.page != `LAST_PAGE)
			|=> (st_ff.off == '0) && (st_ff.page == 13'($past(st_ff.page) + 13'h0001));
	endproperty
	a_page_cross: assert property (p_page_cross)
		else $error("Page crossover went wrong");

	property p_array_wrap;
		(fire && st_ff.off >= last_off && st_ff.page == `LAST_PAGE)
			|=> (st_ff.page == '0) && (st_ff.off == '0);
	endproperty
	a_array_wrap: assert property (p_array_wrap)
		else $error("Array end did not wrap to page zero");

	property p_addr_step;
		(fire && st_ff.off < last_off) |=> (st_ff.off == 10'($past(st_ff.off) + 10'h001));
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("Address counter did not step by one");

	property p_msb_first;
		(sck_rise && st_ff.phase == ST_OPCODE && !cs_n_s && rstn_s) |=> (st_ff.op[0] == $past(si_s));
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("Opcode bit not shifted in at the bottom");

	property p_deselect_clear;
		cs_n_s |=> (st_ff.bits == '0);
	endproperty
	a_deselect_clear: assert property (p_deselect_clear)
		else $error("Bit count survived deselect");

endmodule

// file: dv/array_model.sv
module array_model
(
	input  wire logic        mclk,       // System clock.
	input  wire logic        reset,      // Synchronous reset, active high.
	input  wire logic        slow,       // Throttle grants and answers.
	input  wire logic        arr_req,    // Byte request from the front end.
	output logic             arr_gnt,    // Request accepted.
	input  wire logic [12:0] arr_page,   // Requested page.
	input  wire logic [9:0]  arr_off,    // Requested byte offset.
	output logic             arr_rvalid, // Byte returned.
	input  wire logic        arr_rready, // Front end takes the byte.
	output logic      [7:0]  arr_rdata   // Returned byte.
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] pend_mem [0:15];
	logic [3:0] wr_ff = 4'h0;
	logic [3:0] rd_ff = 4'h0;
	logic [4:0] cnt_ff = 5'h00;
	logic [7:0] cyc_ff = 8'h00;

	// Slow mode halves grants and answers, so the read-ahead path sees gaps.
	assign arr_gnt    = !slow || cyc_ff[0];
	assign arr_rvalid = (cnt_ff != 5'h00) && (!slow || cyc_ff[1]);
	assign arr_rdata  = arr_rvalid ? pend_mem[rd_ff] : cyc_ff;

	// Array contents are a simple sum of page and offset; answers keep request order.
	// Only non-blocking updates, so the front end never races the answer it samples.
	always @(posedge mclk)
	begin
		cyc_ff <= cyc_ff + 8'h01;
		if (reset)
		begin
			wr_ff  <= 4'h0;
			rd_ff  <= 4'h0;
			cnt_ff <= 5'h00;
		end
		else
		begin
			if (arr_req && arr_gnt)
			begin
				pend_mem[wr_ff] <= arr_page[7:0] + arr_off[7:0];
				wr_ff <= wr_ff + 4'h1;
			end
			if (arr_rvalid && arr_rready)
				rd_ff <= rd_ff + 4'h1;
			cnt_ff <= cnt_ff + {4'h0, arr_req && arr_gnt} - {4'h0, arr_rvalid && arr_rready};
		end
	end
endmodule

// file: dv/serial_flash_continuous_read_tb.sv
module serial_flash_continuous_read_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        rst_pin_n = 1'b1;
	logic        cs_n = 1'b1;
	logic        sck = 1'b0;
	logic        si = 1'b0;
	logic        page_size_512 = 1'b0;
	logic        slow = 1'b0;
	logic        so;
	logic        so_oe;
	logic        arr_req;
	logic        arr_gnt;
	logic [12:0] arr_page;
	logic [9:0]  arr_off;
	logic        arr_rvalid;
	logic        arr_rready;
	logic [7:0]  arr_rdata;
	logic [9:0]  cmd_buf_off;
	logic        saw_full = 1'b0;
	int          err_count = 0;
	int          check_count = 0;

	// Clock at 10 MHz.
	always #50 mclk = ~mclk;

	serial_flash_continuous_read dut
	(
		.mclk          (mclk),
		.reset         (reset),
		.rst_pin_n     (rst_pin_n),
		.cs_n          (cs_n),
		.sck           (sck),
		.si            (si),
		.so            (so),
		.so_oe         (so_oe),
		.page_size_512 (page_size_512),
		.arr_req       (arr_req),
		.arr_gnt       (arr_gnt),
		.arr_page      (arr_page),
		.arr_off       (arr_off),
		.arr_rvalid    (arr_rvalid),
		.arr_rready    (arr_rready),
		.arr_rdata     (arr_rdata),
		.cmd_buf_off   (cmd_buf_off)
	);

	array_model mem
	(
		.mclk       (mclk),
		.reset      (reset),
		.slow       (slow),
		.arr_req    (arr_req),
		.arr_gnt    (arr_gnt),
		.arr_page   (arr_page),
		.arr_off    (arr_off),
		.arr_rvalid (arr_rvalid),
		.arr_rready (arr_rready),
		.arr_rdata  (arr_rdata)
	);

	// Remember whether the read-ahead buffer ever filled up and refused.
	always @(posedge mclk)
		if (!reset && !arr_rready)
			saw_full <= 1'b1;

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// link clock rate
	// One byte, MSB first: fall and set SI, then rise and sample SO, 800 ns a bit.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			si = tx[i];
			repeat (4) @(negedge mclk);
			sck = 1'b1;
			rx[i] = so_oe ? so : 1'bz;
			repeat (4) @(negedge mclk);
		end
	endtask

	// Whole frame; select stays low from opcode to the last data byte.
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd, input int nr,
		input bit m3, input bit p5, input bit ok, input bit hr);
		logic [7:0]  rx;
		logic [12:0] pg;
		logic [9:0]  of;
		pg = p5 ? a[21:9] : a[22:10];
		of = p5 ? {1'b0, a[8:0]} : a[9:0];
		sck = m3;
		page_size_512 = p5;
		cs_n = 1'b0;
		repeat (3) @(negedge mclk);
		xfer(op, rx);
		chk({2'b00, rx}, {2'b00, 8'hZZ});
		for (int i = 2; i >= 0; i--)
		begin
			xfer(a[i*8 +: 8], rx);
			chk({2'b00, rx}, {2'b00, 8'hZZ});
		end
		for (int i = 0; i < nd; i++)
		begin
			xfer(8'hA5, rx);
			chk({2'b00, rx}, {2'b00, 8'hZZ});
		end
		if (ok)
			chk(cmd_buf_off, p5 ? {1'b0, a[8:0]} : a[9:0]);
		for (int i = 0; i < nr; i++)
		begin
			xfer(8'h00, rx);
			chk({2'b00, rx}, {2'b00, ok ? pg[7:0] + of[7:0] : 8'hZZ});
			if (of == (p5 ? 10'h1FF : 10'h20F))
			begin
				of = 10'h000;
				pg = pg + 13'h0001;
			end
			else
				of = of + 10'h001;
			if (hr)
			begin
				rst_pin_n = 1'b0;
				repeat (4) @(negedge mclk);
				chk({9'h000, so_oe}, 10'h000);
				rst_pin_n = 1'b1;
				break;
			end
		end
		sck = m3;
		repeat (2) @(negedge mclk);
		cs_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk({9'h000, so_oe}, 10'h000);
		repeat (40) @(negedge mclk);
	endtask

	// Legacy read, mode 0, 528-byte pages, crossing a page end.
	task automatic t_legacy();
		frame(8'hE8, {1'b0, 13'h0005, 10'h20E}, 4, 4, 1'b0, 1'b0, 1'b1, 1'b0);
		chk({9'h000, saw_full}, 10'h001);
		$display("test legacy done");
	endtask

	// Fast read, mode 3, 512-byte pages, wrapping past the last page, slow array.
	task automatic t_fast_wrap();
		slow = 1'b1;
		frame(8'h1B, {2'b00, 13'h1FFF, 9'h1FE}, 2, 4, 1'b1, 1'b1, 1'b1, 1'b0);
		slow = 1'b0;
		$display("test fast wrap done");
	endtask

	// Unknown opcode leaves the output floating for the whole frame.
	task automatic t_unknown();
		frame(8'h03, 24'h000000, 2, 2, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test unknown done");
	endtask

	// Reset pin pulled in mid-read, then a fresh fast read in 528 mode.
	task automatic t_pin_reset();
		frame(8'h1B, {1'b0, 13'h0002, 10'h010}, 2, 3, 1'b0, 1'b0, 1'b1, 1'b1);
		frame(8'h1B, {1'b0, 13'h0003, 10'h0FF}, 2, 3, 1'b0, 1'b0, 1'b1, 1'b0);
		$display("test pin reset done");
	endtask

	// A hang is cut short and counted.
	initial
	begin
		repeat (100000) @(posedge mclk);
		err_count++;
		print_verdict();
	end

	initial
	begin
		repeat (10) @(negedge mclk);
		reset = 1'b0;
		repeat (5) @(negedge mclk);
		t_legacy();
		t_fast_wrap();
		t_unknown();
		t_pin_reset();
		print_verdict();
	end
endmodule
